// [uart_frame_config_status_test.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) n_tests++; \
  if ((got) !== (ex)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end
module uart_frame_config_status_test;
  import ufc_pkg::*;
  localparam int BC = 8;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, rxd, txd, cts_n, lde, irq, go, xon, xbit, nbusy, dl, da, acc;
  logic [UFC_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [7:0] nd, v, d;
  logic [11:0] f;
  logic [7:0] fr [4] = '{8'h3c, 8'h11, 8'h55, 8'h22};
  logic [3:0] tab [4] = '{4'b1111, 4'b0101, 4'b0011, 4'b0010};
  int fails, n_tests, m, k;
  ufc_top #(.BIT_CYCLES(BC)) i_ufc_top (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .rxd, .txd, .cts_n, .line_driver_enable(lde), .rx_data_irq(irq));
  ufc_node #(.BIT_CYCLES(BC)) i_ufc_node (.aclk, .go, .data(nd), .extra_on(xon), .extra(xbit),
    .rxd, .busy(nbusy));
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic final_report;
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] dv);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, dv};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [11:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    v = rdata[7:0];
    r = rresp;
  endtask
  task automatic rc(input logic [11:0] idx, input logic [7:0] ex, input string nm);
    rd(idx);
    `CHK(nm, ex, v)
  endtask
  task automatic send(input logic [7:0] dv, input logic xo, input logic x);
    nd <= dv;
    xon <= xo;
    xbit <= x;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    while (nbusy) @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask
  // sample the transmit line mid-bit, then the driver enable at the last bit and after
  task automatic cap(input int nb);
    f = '1;
    do @(posedge aclk); while (txd !== 1'b0);
    repeat (BC / 2 - 1) @(posedge aclk);
    f[0] = txd;
    for (int i = 1; i <= nb; i++)
    begin
      repeat (BC) @(posedge aclk);
      f[i] = txd;
    end
    dl = lde;
    repeat (BC) @(posedge aclk);
    da = lde;
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    final_report();
  end
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, go, xon, xbit} = '0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata, nd} = '0;
    wstrb = 4'h1;
    cts_n = 1'b1;
    fails = 0;
    n_tests = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(UFC_IDX_CTRL_A, 8'h00, "ctrl_a reset");
    rc(UFC_IDX_CTRL_B, 8'h00, "ctrl_b reset");
    rc(UFC_IDX_STAT_EXT, 8'h00, "stat_ext reset");
    `CHK("lde idle", 1'b0, lde)
    rd(12'hf50);
    `CHK("unmapped rd", {UFC_RESP_SLVERR, 8'h00}, {r, v})
    wr(12'hf50, 8'hff);
    `CHK("unmapped wr", UFC_RESP_SLVERR, r)
    for (k = 0; k < 4; k++)
    begin
      d = 8'h35 + 8'(k * 29);
      wr(UFC_IDX_CTRL_A, 8'h00);
      wr(UFC_IDX_CTRL_A, {4'b1001, k[0], 1'b0, k[1], 1'b0});
      wr(UFC_IDX_DATA, d);
      cap(10 + k / 2);
      `CHK("parity frame", {2'b11, ^d ^ k[0], d, 1'b0}, f)
      `CHK("stop count", 2'b10, {dl, da})
    end
    for (k = 0; k < 2; k++)
    begin
      wr(UFC_IDX_CTRL_A, 8'h00);
      wr(UFC_IDX_CTRL_B, {3'b010, k[0], 4'b1000});
      wr(UFC_IDX_CTRL_A, 8'h90);
      `CHK("lde idle inv", 1'b1, lde)
      wr(UFC_IDX_DATA, 8'h01);
      cap(10);
      `CHK("ninth frame", {2'b11, k[0], 8'h01, 1'b0}, f)
      `CHK("lde inv", 2'b01, {dl, da})
    end
    wr(UFC_IDX_CTRL_A, 8'h00);
    wr(UFC_IDX_CTRL_B, 8'h00);
    wr(UFC_IDX_CTRL_A, 8'h20);
    wr(UFC_IDX_DATA, 8'hc3);
    repeat (BC / 2) @(posedge aclk);
    `CHK("tx off", 1'b1, txd)
    wr(UFC_IDX_CTRL_A, 8'ha0);
    repeat (BC / 2) @(posedge aclk);
    `CHK("cts gate", 1'b1, txd)
    cts_n <= 1'b0;
    cap(9);
    `CHK("cts frame", {3'b111, 8'hc3, 1'b0}, f)
    cts_n <= 1'b1;
    wr(UFC_IDX_CTRL_A, 8'h00);
    wr(UFC_IDX_CTRL_A, 8'h84);
    repeat (2 * BC) @(posedge aclk);
    `CHK("break", 1'b0, txd)
    wr(UFC_IDX_CTRL_A, 8'h00);
    repeat (2 * BC) @(posedge aclk);
    `CHK("break off", 1'b1, txd)
    wr(UFC_IDX_CTRL_A, 8'hc1);
    wr(UFC_IDX_DATA, 8'ha6);
    repeat (BC / 2) @(posedge aclk);
    `CHK("loop txd", 1'b1, txd)
    repeat (12 * BC + BC / 2) @(posedge aclk);
    `CHK("loop irq", 1'b1, irq)
    rc(UFC_IDX_DATA, 8'ha6, "loop data");
    wr(UFC_IDX_CTRL_A, 8'h00);
    send(8'h77, 1'b0, 1'b0);
    `CHK("rx off", 1'b0, irq)
    wr(UFC_IDX_CTRL_A, 8'h58);
    for (k = 0; k < 2; k++)
    begin
      send(8'h01, 1'b1, k[0]);
      rd(UFC_IDX_STAT0);
      `CHK("rx parity", k[0], v[6])
      rc(UFC_IDX_DATA, 8'h01, "rx data");
    end
    wr(UFC_IDX_ADDR_CMP, 8'h3c);
    for (m = 0; m < 4; m++)
    begin
      wr(UFC_IDX_CTRL_A, 8'h00);
      wr(UFC_IDX_CTRL_B, {m[1], 1'b1, m[0], 5'h00});
      wr(UFC_IDX_CTRL_A, 8'h40);
      for (k = 0; k < 4; k++)
      begin
        send(fr[k], 1'b1, !k[0]);
        acc = tab[m][k];
        `CHK("filter irq", acc, irq)
        rc(UFC_IDX_STAT_EXT, {6'h00, acc & k[0], !k[0]}, "stat_ext");
        if (acc)
          rc(UFC_IDX_DATA, fr[k], "rx byte");
      end
    end
    send(8'h3c, 1'b1, 1'b1);
    wr(UFC_IDX_STAT_EXT, 8'h02);
    rc(UFC_IDX_STAT_EXT, 8'h03, "flag write");
    rd(UFC_IDX_DATA);
    rc(UFC_IDX_STAT_EXT, 8'h00, "flag clear");
    final_report();
  end
endmodule

// [ufc_node.sv]
`timescale 1ns/1ps
module ufc_node #(
  parameter int unsigned BIT_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic go,
  input wire logic [7:0] data,
  input wire logic extra_on,
  input wire logic extra,
  output logic rxd,
  output logic busy
);
  logic [10:0] frame;
  initial
  begin
    rxd = 1'b1;
    busy = 1'b0;
    forever
    begin
      @(posedge aclk);
      if (go)
      begin
        frame = {1'b1, extra_on ? extra : 1'b1, data, 1'b0};
        busy <= 1'b1;
        for (int i = 0; i < 11; i++)
        begin
          rxd <= frame[i];
          repeat (BIT_CYCLES) @(posedge aclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// [ufc_pkg.sv]
package ufc_pkg;
  localparam int unsigned UFC_CLK_HZ = 250_000_000;
  localparam int unsigned UFC_BAUD = 115_200;
  localparam int unsigned UFC_BIT_CYCLES = UFC_CLK_HZ / UFC_BAUD;
  localparam int UFC_CNT_W = 16;
  localparam int UFC_ADDR_W = 14;
  // register indices; byte address is four times the index
  localparam logic [11:0] UFC_IDX_DATA = 12'hf40;
  localparam logic [11:0] UFC_IDX_STAT0 = 12'hf41;
  localparam logic [11:0] UFC_IDX_CTRL_A = 12'hf42;
  localparam logic [11:0] UFC_IDX_CTRL_B = 12'hf43;
  localparam logic [11:0] UFC_IDX_STAT_EXT = 12'hf44;
  localparam logic [11:0] UFC_IDX_ADDR_CMP = 12'hf45;
  localparam logic [7:0] UFC_CTRL_A_RST = 8'h00;
  localparam logic [7:0] UFC_CTRL_B_RST = 8'h00;
  localparam logic [7:0] UFC_ADDR_CMP_RST = 8'h00;
  // uart_ctrl_a fields
  localparam int UFC_A_TX_EN = 7;
  localparam int UFC_A_RX_EN = 6;
  localparam int UFC_A_FLOW = 5;
  localparam int UFC_A_PAR_ON = 4;
  localparam int UFC_A_PAR_ODD = 3;
  localparam int UFC_A_BREAK = 2;
  localparam int UFC_A_STOP2 = 1;
  localparam int UFC_A_LOOP = 0;
  // uart_ctrl_b fields
  localparam int UFC_B_MODE_HI = 7;
  localparam int UFC_B_NINE = 6;
  localparam int UFC_B_MODE_LO = 5;
  localparam int UFC_B_TX_NINTH = 4;
  localparam int UFC_B_DRV_POL = 3;
  // uart_status_ext fields
  localparam int UFC_S_FRAME = 1;
  localparam int UFC_S_NINTH = 0;
  localparam logic [1:0] UFC_RESP_OKAY = 2'b00;
  localparam logic [1:0] UFC_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    UFC_FILT_ALL = 2'b00,
    UFC_FILT_ADDR = 2'b01,
    UFC_FILT_MATCH_RUN = 2'b10,
    UFC_FILT_MATCH_DATA = 2'b11
  } ufc_filter_t;

  typedef enum logic [4:0] {
    UFC_ST_IDLE = 5'b00001,
    UFC_ST_START = 5'b00010,
    UFC_ST_DATA = 5'b00100,
    UFC_ST_EXTRA = 5'b01000,
    UFC_ST_STOP = 5'b10000
  } ufc_state_t;

  // parity bit for 8 data bits, even when odd is 0
  function automatic logic ufc_parity(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction
endpackage

// [ufc_rx.sv]
`timescale 1ns/1ps
module ufc_rx #(
  parameter int unsigned BIT_CYCLES = ufc_pkg::UFC_BIT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  ufc_rx_if.rx port
);
  import ufc_pkg::*;

  ufc_state_t state_reg;
  logic [UFC_CNT_W-1:0] cnt_reg;
  logic [2:0] bit_reg;
  logic [7:0] shift_reg;

  // receiver idles while disabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !port.enable)
    begin
      state_reg <= UFC_ST_IDLE;
      cnt_reg <= '0;
      bit_reg <= '0;
      shift_reg <= '0;
      port.valid <= 1'b0;
      port.data <= '0;
      port.extra <= 1'b0;
      port.frame_err <= 1'b0;
    end
    else
    begin
      port.valid <= 1'b0;
      if (state_reg != UFC_ST_IDLE && cnt_reg != '0)
      begin
        cnt_reg <= cnt_reg - 1'b1;
      end
      else
      begin
        unique case (state_reg)
          UFC_ST_IDLE:
          begin
            if (!port.line)
            begin
              state_reg <= UFC_ST_START;
              cnt_reg <= UFC_CNT_W'(BIT_CYCLES / 2 - 1);
            end
          end
          UFC_ST_START:
          begin
            state_reg <= port.line ? UFC_ST_IDLE : UFC_ST_DATA;
            cnt_reg <= UFC_CNT_W'(BIT_CYCLES - 1);
            bit_reg <= '0;
          end
          UFC_ST_DATA:
          begin
            shift_reg <= {port.line, shift_reg[7:1]};
            cnt_reg <= UFC_CNT_W'(BIT_CYCLES - 1);
            bit_reg <= bit_reg + 1'b1;
            if (bit_reg == 3'd7)
            begin
              state_reg <= port.extra_on ? UFC_ST_EXTRA : UFC_ST_STOP;
            end
          end
          UFC_ST_EXTRA:
          begin
            port.extra <= port.line;
            cnt_reg <= UFC_CNT_W'(BIT_CYCLES - 1);
            state_reg <= UFC_ST_STOP;
          end
          UFC_ST_STOP:
          begin
            port.data <= shift_reg;
            port.frame_err <= !port.line;
            port.valid <= 1'b1;
            state_reg <= UFC_ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// [ufc_rx_if.sv]
`timescale 1ns/1ps
interface ufc_rx_if;
  logic enable;
  logic extra_on;
  logic line;
  logic valid;
  logic [7:0] data;
  logic extra;
  logic frame_err;
  modport rx (input enable, input extra_on, input line,
              output valid, output data, output extra, output frame_err);
  modport core (output enable, output extra_on, output line,
                input valid, input data, input extra, input frame_err);
endinterface

// [ufc_sva.sv]
`timescale 1ns/1ps
module ufc_sva #(
  parameter int unsigned BIT_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ufc_pkg::UFC_ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic txd,
  input wire logic rx_data_irq
);
  import ufc_pkg::*;
  logic [15:0] low_cnt_reg;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // length of the current low run on the transmit line
  always_ff @(posedge aclk)
  begin
    if (!aresetn || txd)
      low_cnt_reg <= 16'h0000;
    else
      low_cnt_reg <= low_cnt_reg + 16'h0001;
  end
  property p_wr_resp;
    awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_done;
    bvalid && bready |=> !bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response repeated");
  property p_rd_resp;
    arvalid && arready |=> rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response late");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_r_busy;
    rvalid |-> !arready;
  endproperty
  a_r_busy: assert property (p_r_busy) else $error("read address taken while busy");
  property p_r_fmt;
    rvalid |-> rdata[31:8] == 24'h0 && (rresp != UFC_RESP_SLVERR || rdata == 32'h0);
  endproperty
  a_r_fmt: assert property (p_r_fmt) else $error("read data malformed");
  property p_low_len;
    $rose(txd) |-> low_cnt_reg >= BIT_CYCLES;
  endproperty
  a_low_len: assert property (p_low_len) else $error("low pulse shorter than a bit");
  property p_irq_clr;
    arvalid && arready && araddr[13:2] == UFC_IDX_DATA |-> ##[1:2] !rx_data_irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("data read left request");
  c_slverr: cover property (bvalid && bresp == UFC_RESP_SLVERR);
  c_irq: cover property ($rose(rx_data_irq));
  c_txd: cover property ($fell(txd));
endmodule
bind ufc_top ufc_sva #(.BIT_CYCLES(BIT_CYCLES)) i_ufc_sva (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
  .rdata, .rresp, .txd, .rx_data_irq);

// [ufc_top.sv]
`timescale 1ns/1ps
// Function
// - frame start flag marks first data byte of frame; cleared by data read
// - rx ninth bit holds last received multiprocessor bit; cleared by data read
// - transmitter runs only with enable set, and clear-to-send low when gated
// - clear-to-send ignored unless flow gating set, then acts as transmit enable
// - receiver works only while its enable bit is one
// - parity adds a bit on transmit and receive; nine-bit mode overrides it
// - parity sense zero gives even, one gives odd, both directions
// - send break forces transmit line low outside loopback; a character in progress keeps shifting underneath
// - stop count zero gives one stop bit, one gives two
// - loopback routes transmitted data into the receiver
// - nine-bit enable selects multiprocessor format
// - filter 00: every received byte requests interrupt
// - filter 01: only address bytes request interrupt
// - filter 10: matching address and following data bytes until mismatch
// - filter 11: data bytes after a matching address only
// - in nine-bit mode transmit ninth bit control is sent as ninth bit
// - line driver enable active high with polarity zero, low with one
// - upper filter bit compares address bytes; data available only on match
module ufc_top #(
  parameter int unsigned BIT_CYCLES = ufc_pkg::UFC_BIT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ufc_pkg::UFC_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ufc_pkg::UFC_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  output logic line_driver_enable,
  output logic rx_data_irq
);
  import ufc_pkg::*;

  logic rxd_meta_reg;
  logic rxd_sync_reg;
  logic cts_meta_reg;
  logic cts_sync_reg;
  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [7:0] addr_cmp_reg;
  logic [7:0] tx_hold_reg;
  logic tx_hold_full_reg;
  logic [7:0] rx_data_reg;
  logic rda_reg;
  logic perr_reg;
  logic ferr_reg;
  logic ovr_reg;
  logic frame_start_reg;
  logic rx_ninth_reg;
  logic match_reg;
  logic first_pending_reg;
  logic aw_held_reg;
  logic [11:0] aw_idx_reg;
  logic w_held_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  ufc_state_t tx_state_reg;
  logic [UFC_CNT_W-1:0] tx_cnt_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic tx_extra_reg;
  logic tx_line_reg;
  logic tx_stop_left_reg;
  logic txd_reg;
  logic de_reg;

  logic tx_enable;
  logic rx_enable;
  logic flow_gate_on;
  logic parity_on;
  logic parity_odd;
  logic force_break_out;
  logic two_stop;
  logic loopback_on;
  logic nine_bit_mode_on;
  logic tx_ninth_bit;
  logic driver_polarity;
  logic [1:0] mp_irq_filter_mode;
  logic tx_run;
  logic tx_take;
  logic tx_line_int;
  logic wr_fire;
  logic wr_lane;
  logic rd_fire;
  logic [11:0] rd_idx;
  logic rx_read;
  logic rx_is_addr;
  logic rx_hit;
  logic rx_accept;
  logic rx_perr;

  ufc_rx_if rx_bus();

  ufc_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .port(rx_bus.rx)
  );

  function automatic logic idx_mapped(input logic [11:0] idx);
    return idx >= UFC_IDX_DATA && idx <= UFC_IDX_ADDR_CMP;
  endfunction

  assign tx_enable = ctrl_a_reg[UFC_A_TX_EN];
  assign rx_enable = ctrl_a_reg[UFC_A_RX_EN];
  assign flow_gate_on = ctrl_a_reg[UFC_A_FLOW];
  assign parity_on = ctrl_a_reg[UFC_A_PAR_ON];
  assign parity_odd = ctrl_a_reg[UFC_A_PAR_ODD];
  assign force_break_out = ctrl_a_reg[UFC_A_BREAK];
  assign two_stop = ctrl_a_reg[UFC_A_STOP2];
  assign loopback_on = ctrl_a_reg[UFC_A_LOOP];
  assign nine_bit_mode_on = ctrl_b_reg[UFC_B_NINE];
  assign tx_ninth_bit = ctrl_b_reg[UFC_B_TX_NINTH];
  assign driver_polarity = ctrl_b_reg[UFC_B_DRV_POL];
  assign mp_irq_filter_mode = {ctrl_b_reg[UFC_B_MODE_HI], ctrl_b_reg[UFC_B_MODE_LO]};

  // pin synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      cts_meta_reg <= 1'b1;
      cts_sync_reg <= 1'b1;
    end
    else
    begin
      rxd_meta_reg <= rxd;
      rxd_sync_reg <= rxd_meta_reg;
      cts_meta_reg <= cts_n;
      cts_sync_reg <= cts_meta_reg;
    end
  end

  // bus handshakes
  assign awready = !aw_held_reg;
  assign wready = !w_held_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_lane = wr_fire && w_lane0_reg;
  assign rd_fire = arvalid && !rvalid_reg;
  assign rd_idx = araddr[UFC_ADDR_W-1:2];
  assign rx_read = rd_fire && rd_idx == UFC_IDX_DATA;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_lane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= UFC_RESP_OKAY;
    end
    else
    begin
      if (awvalid && !aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        aw_idx_reg <= awaddr[UFC_ADDR_W-1:2];
      end
      if (wvalid && !w_held_reg)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata[7:0];
        w_lane0_reg <= wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= idx_mapped(aw_idx_reg) ? UFC_RESP_OKAY : UFC_RESP_SLVERR;
      end
      else if (bvalid_reg && bready)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= UFC_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= idx_mapped(rd_idx) ? UFC_RESP_OKAY : UFC_RESP_SLVERR;
      unique case (rd_idx)
        UFC_IDX_DATA: rdata_reg <= {24'h000000, rx_data_reg};
        UFC_IDX_STAT0: rdata_reg <= {24'h000000, rda_reg, perr_reg, ovr_reg, ferr_reg, 1'b0,
                                     !tx_hold_full_reg, tx_state_reg == UFC_ST_IDLE, cts_sync_reg};
        UFC_IDX_CTRL_A: rdata_reg <= {24'h000000, ctrl_a_reg};
        UFC_IDX_CTRL_B: rdata_reg <= {24'h000000, ctrl_b_reg};
        UFC_IDX_STAT_EXT: rdata_reg <= {30'h00000000, frame_start_reg, rx_ninth_reg};
        UFC_IDX_ADDR_CMP: rdata_reg <= {24'h000000, addr_cmp_reg};
        default: rdata_reg <= '0;
      endcase
    end
    else if (rvalid_reg && rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  // control registers; bits 7 to 2 of status_ext are not stored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_a_reg <= UFC_CTRL_A_RST;
      ctrl_b_reg <= UFC_CTRL_B_RST;
      addr_cmp_reg <= UFC_ADDR_CMP_RST;
    end
    else if (wr_lane)
    begin
      if (aw_idx_reg == UFC_IDX_CTRL_A)
      begin
        ctrl_a_reg <= w_data_reg;
      end
      if (aw_idx_reg == UFC_IDX_CTRL_B)
      begin
        ctrl_b_reg <= w_data_reg;
      end
      if (aw_idx_reg == UFC_IDX_ADDR_CMP)
      begin
        addr_cmp_reg <= w_data_reg;
      end
    end
  end

  // transmitter
  assign tx_run = tx_enable && (!flow_gate_on || !cts_sync_reg);
  assign tx_take = tx_run && tx_state_reg == UFC_ST_IDLE && tx_hold_full_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_hold_reg <= '0;
      tx_hold_full_reg <= 1'b0;
    end
    else if (wr_lane && aw_idx_reg == UFC_IDX_DATA && (!tx_hold_full_reg || tx_take))
    begin
      tx_hold_reg <= w_data_reg;
      tx_hold_full_reg <= 1'b1;
    end
    else if (tx_take)
    begin
      tx_hold_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state_reg <= UFC_ST_IDLE;
      tx_cnt_reg <= '0;
      tx_bit_reg <= '0;
      tx_shift_reg <= '0;
      tx_extra_reg <= 1'b0;
      tx_line_reg <= 1'b1;
      tx_stop_left_reg <= 1'b0;
    end
    else if (tx_run)
    begin
      if (tx_state_reg != UFC_ST_IDLE && tx_cnt_reg != '0)
      begin
        tx_cnt_reg <= tx_cnt_reg - 1'b1;
      end
      else
      begin
        tx_cnt_reg <= UFC_CNT_W'(BIT_CYCLES - 1);
        unique case (tx_state_reg)
          UFC_ST_IDLE:
          begin
            if (tx_hold_full_reg)
            begin
              tx_shift_reg <= tx_hold_reg;
              tx_extra_reg <= nine_bit_mode_on ? tx_ninth_bit
                            : ufc_parity(tx_hold_reg, parity_odd);
              tx_line_reg <= 1'b0;
              tx_state_reg <= UFC_ST_START;
            end
          end
          UFC_ST_START:
          begin
            tx_line_reg <= tx_shift_reg[0];
            tx_bit_reg <= '0;
            tx_state_reg <= UFC_ST_DATA;
          end
          UFC_ST_DATA:
          begin
            tx_shift_reg <= tx_shift_reg >> 1;
            tx_bit_reg <= tx_bit_reg + 1'b1;
            tx_stop_left_reg <= two_stop;
            if (tx_bit_reg != 3'd7)
            begin
              tx_line_reg <= tx_shift_reg[1];
            end
            else if (nine_bit_mode_on || parity_on)
            begin
              tx_line_reg <= tx_extra_reg;
              tx_state_reg <= UFC_ST_EXTRA;
            end
            else
            begin
              tx_line_reg <= 1'b1;
              tx_state_reg <= UFC_ST_STOP;
            end
          end
          UFC_ST_EXTRA:
          begin
            tx_line_reg <= 1'b1;
            tx_state_reg <= UFC_ST_STOP;
          end
          UFC_ST_STOP:
          begin
            tx_stop_left_reg <= 1'b0;
            if (!tx_stop_left_reg)
            begin
              tx_state_reg <= UFC_ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign tx_line_int = force_break_out ? 1'b0 : tx_line_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txd_reg <= 1'b1;
      de_reg <= 1'b0;
    end
    else
    begin
      txd_reg <= loopback_on ? 1'b1 : tx_line_int;
      de_reg <= (tx_state_reg != UFC_ST_IDLE) ^ driver_polarity;
    end
  end

  assign txd = txd_reg;
  assign line_driver_enable = de_reg;

  // receiver configuration and result handling
  assign rx_bus.enable = rx_enable;
  assign rx_bus.extra_on = nine_bit_mode_on || parity_on;
  assign rx_bus.line = loopback_on ? tx_line_int : rxd_sync_reg;
  assign rx_is_addr = nine_bit_mode_on && rx_bus.extra;
  assign rx_hit = rx_bus.data == addr_cmp_reg;
  assign rx_perr = !nine_bit_mode_on && parity_on
                   && rx_bus.extra != ufc_parity(rx_bus.data, parity_odd);

  always_comb
  begin
    rx_accept = 1'b1;
    if (nine_bit_mode_on)
    begin
      unique case (mp_irq_filter_mode)
        UFC_FILT_ALL: rx_accept = 1'b1;
        UFC_FILT_ADDR: rx_accept = rx_is_addr;
        UFC_FILT_MATCH_RUN: rx_accept = rx_is_addr ? rx_hit : match_reg;
        UFC_FILT_MATCH_DATA: rx_accept = !rx_is_addr && match_reg;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      match_reg <= 1'b0;
      first_pending_reg <= 1'b0;
    end
    else if (rx_bus.valid && nine_bit_mode_on)
    begin
      first_pending_reg <= rx_is_addr;
      if (rx_is_addr)
      begin
        match_reg <= rx_hit;
      end
    end
  end

  // clears first, so a byte landing with a read is kept
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_data_reg <= '0;
      rda_reg <= 1'b0;
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
      ovr_reg <= 1'b0;
      frame_start_reg <= 1'b0;
      rx_ninth_reg <= 1'b0;
    end
    else
    begin
      if (rx_read)
      begin
        rda_reg <= 1'b0;
        perr_reg <= 1'b0;
        ferr_reg <= 1'b0;
        ovr_reg <= 1'b0;
        frame_start_reg <= 1'b0;
        rx_ninth_reg <= 1'b0;
      end
      if (wr_lane && aw_idx_reg == UFC_IDX_STAT_EXT)
      begin
        frame_start_reg <= w_data_reg[UFC_S_FRAME];
      end
      if (rx_bus.valid)
      begin
        rx_ninth_reg <= rx_is_addr;
      end
      if (rx_bus.valid && rx_accept)
      begin
        rx_data_reg <= rx_bus.data;
        rda_reg <= 1'b1;
        ovr_reg <= rda_reg && !rx_read;
        perr_reg <= rx_perr;
        ferr_reg <= rx_bus.frame_err;
        frame_start_reg <= !rx_is_addr && first_pending_reg;
      end
    end
  end

  assign rx_data_irq = rda_reg;
endmodule
